/* logic/sqc_hold_release.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// synchronised pin that fires once on release after a long hold
// ------------------------------------------------------------
module sqc_hold_release #(
    parameter int unsigned HOLD_CYC = sqc_pkg::CLEAR_HOLD_CYC
) (
    input  wire logic  clk,
    input  wire logic  reset_n,
    input  wire logic  ce,
    input  wire logic  pin,
    output logic       released
);
    localparam int unsigned CW = $clog2(HOLD_CYC + 1);

    logic          sync_a;
    logic          sync_b;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_released;

    always_comb
    begin
        next_cnt      = cnt;
        next_released = 1'b0;
        if (sync_b)
        begin
            if (cnt != CW'(HOLD_CYC))
                next_cnt = cnt + CW'(1);
        end
        else
        begin
            // a short press is ignored
            next_released = (cnt == CW'(HOLD_CYC));
            next_cnt      = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_a   <= 1'b0;
            sync_b   <= 1'b0;
            cnt      <= '0;
            released <= 1'b0;
        end
        else if (ce)
        begin
            sync_a   <= pin;
            sync_b   <= sync_a;
            cnt      <= next_cnt;
            released <= next_released;
        end
    end

endmodule : sqc_hold_release

/* logic/sqc_run_ctrl.sv */
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps

// Function
// - enable setting applies only after drive reset
// - run key on runs, off stops
// - leaving run clears output points
// - other devices keep values on stop
// - power cycle or held clear terminal clears
// - bad instruction stores code 10 and step
// - enabled engine refuses tuning and analyzer
// - frame format code, initial 1, tool 0
// - parity code, initial 2, tool 1
// - check interval 9999 disables timeout
// - parameter clear restores serial settings
// - remote run/stop from contact, tool, network
// - reject online change and remote-station requests
// - no device value survives power loss
// - ten user slots, 0 to 65535
// - forced terminal image never drives the motor
// - factory lock keeps start valid without key
module sqc_run_ctrl #(
    parameter int unsigned NTERM     = 12,
    parameter int unsigned NOUT      = 16,
    parameter int unsigned NSLOT     = 10,
    parameter int unsigned HOLD_CYC  = sqc_pkg::CLEAR_HOLD_CYC
) (
    input  wire logic                 CLK,
    input  wire logic                 RESET_N,
    input  wire logic                 CE,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [7:0]           PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic      [31:0]          PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    input  wire logic [NTERM-1:0]     TERM_IN,
    input  wire logic                 CLEAR_TERM_IN,
    input  wire logic                 REMOTE_CONTACT_IN,
    input  wire logic                 NET_RUN_REQ,
    input  wire logic                 NET_STOP_REQ,
    input  wire logic                 SCAN_END,
    input  wire logic                 INSTR_FAULT,
    input  wire logic [31:0]          FAULT_STEP,
    input  wire logic [NOUT-1:0]      Y_IMAGE,
    output logic                      ENGINE_RUN,
    output logic      [NOUT-1:0]      OUT_POINTS,
    output logic      [NTERM-1:0]     PROG_INPUTS,
    output logic                      DRIVE_START,
    output logic                      TUNE_ALLOWED,
    output sqc_pkg::sqc_comm_type     COMM_SETTINGS,
    output logic                      COMM_CHECK_EN
);
    localparam int unsigned TW = $clog2(NTERM);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic slot_hit(input logic [7:0] a, output logic [3:0] idx);
        logic [7:0] d;
        d        = a - sqc_pkg::OFS_SLOT0;
        idx      = d[5:2];
        slot_hit = (a >= sqc_pkg::OFS_SLOT0) && (d[1:0] == 2'h0) && (32'(d[7:2]) < NSLOT);
    endfunction : slot_hit

    function automatic logic reg_hit(input logic [7:0] a);
        logic [3:0] i;
        reg_hit = slot_hit(a, i) || a == sqc_pkg::OFS_CTRL || a == sqc_pkg::OFS_ASSIGN
                  || a == sqc_pkg::OFS_COMM || a == sqc_pkg::OFS_CHECK || a == sqc_pkg::OFS_CMD
                  || a == sqc_pkg::OFS_STATUS || a == sqc_pkg::OFS_ERRCODE
                  || a == sqc_pkg::OFS_ERRSTEP || a == sqc_pkg::OFS_FORCE || a == sqc_pkg::OFS_OUTPTS;
    endfunction : reg_hit

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [NTERM-1:0] term_a;
    logic [NTERM-1:0] term_s;
    logic             contact_a;
    logic             contact_s;
    logic             clear_rel;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            term_a    <= '0;
            term_s    <= '0;
            contact_a <= 1'b0;
            contact_s <= 1'b0;
        end
        else if (CE)
        begin
            term_a    <= TERM_IN;
            term_s    <= term_a;
            contact_a <= REMOTE_CONTACT_IN;
            contact_s <= contact_a;
        end
    end

    sqc_hold_release #(
        .HOLD_CYC (HOLD_CYC)
    ) u_clear (
        .clk      (CLK),
        .reset_n  (RESET_N),
        .ce       (CE),
        .pin      (CLEAR_TERM_IN),
        .released (clear_rel)
    );

    // ------------------------------------------------------------
    // bus and settings
    // ------------------------------------------------------------
    logic                  en_pending;
    logic                  op_lock;
    logic [TW-1:0]         asg_term;
    logic [7:0]            asg_code;
    logic [NTERM-1:0]      force_img;
    logic [15:0]           slot [NSLOT];
    logic                  next_pready;
    logic                  next_pslverr;
    logic [31:0]           next_prdata;
    logic                  wr;
    logic [31:0]           cmd;
    logic [3:0]            sidx;
    logic                  shit;
    sqc_pkg::sqc_comm_type next_comm;

    // state of the run group, read back over the bus
    sqc_pkg::sqc_state_type state;
    sqc_pkg::sqc_err_type   err;
    logic                   en_active;
    logic                   reject;

    assign wr  = PSEL & PENABLE & PREADY & PWRITE;
    assign cmd = (wr && PADDR == sqc_pkg::OFS_CMD) ? PWDATA : 32'h0000_0000;

    always_comb
    begin
        next_pready  = PSEL & PENABLE & ~PREADY;
        next_pslverr = next_pready & ~reg_hit(PADDR);
        next_prdata  = 32'h0000_0000;
        shit         = slot_hit(PADDR, sidx);
        if (next_pready && !PWRITE)
        begin
            if (shit)
                next_prdata = {16'h0000, slot[sidx]};
            else
            begin
                unique case (PADDR)
                    sqc_pkg::OFS_CTRL:    next_prdata = 32'({op_lock, en_pending});
                    sqc_pkg::OFS_ASSIGN:  next_prdata = (32'(asg_code) << sqc_pkg::ASG_CODE_LSB) | 32'(asg_term);
                    sqc_pkg::OFS_COMM:    next_prdata = (32'(COMM_SETTINGS.parity) << sqc_pkg::COMM_PAR_LSB)
                                                        | (32'(COMM_SETTINGS.frame) << sqc_pkg::COMM_FRAME)
                                                        | 32'(COMM_SETTINGS.link_speed);
                    sqc_pkg::OFS_CHECK:   next_prdata = 32'(COMM_SETTINGS.check_interval);
                    sqc_pkg::OFS_STATUS:  next_prdata = 32'({en_active, reject, err.flag, en_active,
                                                             state == sqc_pkg::SQC_RUN});
                    sqc_pkg::OFS_ERRCODE: next_prdata = 32'(err.code);
                    sqc_pkg::OFS_ERRSTEP: next_prdata = err.step;
                    sqc_pkg::OFS_FORCE:   next_prdata = 32'(force_img);
                    sqc_pkg::OFS_OUTPTS:  next_prdata = 32'(OUT_POINTS);
                    default:              next_prdata = 32'h0000_0000;
                endcase
            end
        end
        next_comm = COMM_SETTINGS;
        if (wr && PADDR == sqc_pkg::OFS_COMM)
        begin
            next_comm.link_speed = PWDATA[15:0];
            next_comm.frame      = PWDATA[sqc_pkg::COMM_FRAME];
            next_comm.parity     = PWDATA[sqc_pkg::COMM_PAR_LSB +: 2];
        end
        if (wr && PADDR == sqc_pkg::OFS_CHECK)
            next_comm.check_interval = PWDATA[15:0];
        if (cmd[sqc_pkg::CMD_PCLEAR])
            next_comm = sqc_pkg::COMM_INIT;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            PREADY        <= 1'b0;
            PSLVERR       <= 1'b0;
            PRDATA        <= 32'h0000_0000;
            en_pending    <= 1'b0;
            op_lock       <= 1'b0;
            asg_term      <= '0;
            asg_code      <= 8'h00;
            force_img     <= '0;
            COMM_SETTINGS <= sqc_pkg::COMM_INIT;
            COMM_CHECK_EN <= 1'b0;
            for (int i = 0; i < NSLOT; i++)
                slot[i] <= 16'h0000;
        end
        else if (CE)
        begin
            PREADY        <= next_pready;
            PSLVERR       <= next_pslverr;
            PRDATA        <= next_prdata;
            COMM_SETTINGS <= next_comm;
            COMM_CHECK_EN <= next_comm.check_interval != sqc_pkg::CHECK_OFF;
            if (wr && PADDR == sqc_pkg::OFS_CTRL)
            begin
                en_pending <= PWDATA[sqc_pkg::CTRL_ENABLE];
                op_lock    <= PWDATA[sqc_pkg::CTRL_OPLOCK];
            end
            if (wr && PADDR == sqc_pkg::OFS_ASSIGN)
            begin
                asg_term <= PWDATA[sqc_pkg::ASG_TERM_LSB +: TW];
                asg_code <= PWDATA[sqc_pkg::ASG_CODE_LSB +: 8];
            end
            if (wr && PADDR == sqc_pkg::OFS_FORCE)
                force_img <= PWDATA[NTERM-1:0];
            if (wr && shit)
                slot[sidx] <= PWDATA[15:0];
        end
    end

    // ------------------------------------------------------------
    // run control, devices and errors
    // ------------------------------------------------------------
    sqc_pkg::sqc_state_type next_state;
    sqc_pkg::sqc_err_type   next_err;
    logic                   next_en_active;
    logic                   next_reject;
    logic                   rmt_stop;
    logic                   next_rmt_stop;
    logic [NOUT-1:0]        next_out;
    logic                   key_on;
    logic                   run_want;
    logic                   drive_rst;

    always_comb
    begin
        key_on = (asg_code == sqc_pkg::RUN_KEY_CODE) && (32'(asg_term) < NTERM)
                 && term_s[asg_term];
        drive_rst      = clear_rel | cmd[sqc_pkg::CMD_DRESET];
        next_rmt_stop  = rmt_stop;
        if (cmd[sqc_pkg::CMD_RUN] || NET_RUN_REQ)
            next_rmt_stop = 1'b0;
        if (cmd[sqc_pkg::CMD_STOP] || NET_STOP_REQ)
            next_rmt_stop = 1'b1;
        run_want = en_active & key_on & ~rmt_stop & ~contact_s;
        next_state  = state;
        next_out    = OUT_POINTS;
        next_err    = err;
        next_reject = reject;
        unique case (state)
            sqc_pkg::SQC_STOP:
                if (run_want)
                    next_state = sqc_pkg::SQC_RUN;
            sqc_pkg::SQC_RUN:
                if (SCAN_END)
                begin
                    if (run_want)
                        next_out = Y_IMAGE;
                    else
                    begin
                        next_state = sqc_pkg::SQC_STOP;
                        next_out   = '0;
                    end
                end
        endcase
        if (cmd[sqc_pkg::CMD_CLR_ERR])
            next_err.flag = 1'b0;
        if (state == sqc_pkg::SQC_RUN && INSTR_FAULT)
            next_err = '{FAULT_STEP, sqc_pkg::ERR_INSTR_CODE, 1'b1};
        if (cmd[sqc_pkg::CMD_CLR_REJ])
            next_reject = 1'b0;
        if ((en_active && (cmd[sqc_pkg::CMD_TUNE] || cmd[sqc_pkg::CMD_ANALYZE]))
            || cmd[sqc_pkg::CMD_ONLINE] || cmd[sqc_pkg::CMD_REMOTE] || cmd[sqc_pkg::CMD_MEMCLR])
            next_reject = 1'b1;
        next_en_active = en_active;
        if (drive_rst)
        begin
            next_en_active = en_pending;
            next_state     = sqc_pkg::SQC_STOP;
            next_out       = '0;
            next_err       = '0;
            next_rmt_stop  = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            // nothing is latched across power loss
            state        <= sqc_pkg::SQC_STOP;
            err          <= '0;
            en_active    <= 1'b0;
            reject       <= 1'b0;
            rmt_stop     <= 1'b0;
            OUT_POINTS   <= '0;
            ENGINE_RUN   <= 1'b0;
            PROG_INPUTS  <= '0;
            DRIVE_START  <= 1'b0;
            TUNE_ALLOWED <= 1'b1;
        end
        else if (CE)
        begin
            state        <= next_state;
            err          <= next_err;
            en_active    <= next_en_active;
            reject       <= next_reject;
            rmt_stop     <= next_rmt_stop;
            OUT_POINTS   <= next_out;
            ENGINE_RUN   <= next_state == sqc_pkg::SQC_RUN;
            PROG_INPUTS  <= term_s | force_img;
            DRIVE_START  <= term_s[sqc_pkg::START_TERM] & (~op_lock | key_on);
            TUNE_ALLOWED <= ~next_en_active;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_run_scan_stop;
        CE && state == sqc_pkg::SQC_RUN && SCAN_END && !run_want && !drive_rst;
    endsequence

    a_run_needs_enable: assert property (ENGINE_RUN |-> en_active)
        else $error("engine runs while disabled");
    a_start_on_key: assert property (CE && state == sqc_pkg::SQC_STOP && run_want && !drive_rst
        |=> ENGINE_RUN)
        else $error("run key did not start engine");
    a_stop_clears_out: assert property (s_run_scan_stop |=> OUT_POINTS == '0 && !ENGINE_RUN)
        else $error("outputs not cleared on stop");
    a_stop_at_scan: assert property (CE && state == sqc_pkg::SQC_RUN && !SCAN_END && !drive_rst
        |=> state == sqc_pkg::SQC_RUN && $stable(OUT_POINTS))
        else $error("run state left mid scan");
    a_fault_code: assert property (CE && state == sqc_pkg::SQC_RUN && INSTR_FAULT && !drive_rst
        |=> err.code == sqc_pkg::ERR_INSTR_CODE && err.flag && err.step == $past(FAULT_STEP))
        else $error("fault not recorded");
    a_tune_block: assert property (en_active && !drive_rst ##1 1'b1 |-> !TUNE_ALLOWED)
        else $error("tuning allowed while enabled");
    a_param_clear: assert property (CE && cmd[sqc_pkg::CMD_PCLEAR]
        |=> COMM_SETTINGS.link_speed == sqc_pkg::SPEED_INIT && COMM_SETTINGS.parity == sqc_pkg::PARITY_INIT
        && COMM_SETTINGS.frame == sqc_pkg::FRAME_INIT)
        else $error("parameter clear did not restore settings");
    a_clear_release: assert property (CE && clear_rel |=> OUT_POINTS == '0 && !err.flag
        && en_active == $past(en_pending))
        else $error("clear terminal did not reset devices");
    a_reject_online: assert property (CE && cmd[sqc_pkg::CMD_ONLINE] && !cmd[sqc_pkg::CMD_CLR_REJ]
        |=> reject)
        else $error("online change not rejected");
    a_start_lock: assert property (CE && !op_lock && term_s[sqc_pkg::START_TERM] |=> DRIVE_START)
        else $error("start blocked with factory lock");
    a_apb_ready: assert property (CE && PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY || !CE)
        else $error("ready not one cycle");

endmodule : sqc_run_ctrl

/* shared/sqc_pkg.sv */
package sqc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned CLEAR_HOLD_MS   = 100;
    localparam int unsigned CLEAR_HOLD_CYC  = CLK_HZ / 1000 * CLEAR_HOLD_MS;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_ASSIGN  = 8'h04;
    localparam logic [7:0] OFS_COMM    = 8'h08;
    localparam logic [7:0] OFS_CHECK   = 8'h0C;
    localparam logic [7:0] OFS_CMD     = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam logic [7:0] OFS_ERRCODE = 8'h18;
    localparam logic [7:0] OFS_ERRSTEP = 8'h1C;
    localparam logic [7:0] OFS_FORCE   = 8'h20;
    localparam logic [7:0] OFS_OUTPTS  = 8'h24;
    localparam logic [7:0] OFS_SLOT0   = 8'h40;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_ENABLE   = 0;
    localparam int unsigned CTRL_OPLOCK   = 1;
    localparam int unsigned ASG_TERM_LSB  = 0;
    localparam int unsigned ASG_CODE_LSB  = 8;
    localparam int unsigned COMM_FRAME    = 16;
    localparam int unsigned COMM_PAR_LSB  = 20;
    localparam int unsigned CMD_RUN       = 0;
    localparam int unsigned CMD_STOP      = 1;
    localparam int unsigned CMD_PCLEAR    = 2;
    localparam int unsigned CMD_DRESET    = 3;
    localparam int unsigned CMD_TUNE      = 4;
    localparam int unsigned CMD_ANALYZE   = 5;
    localparam int unsigned CMD_ONLINE    = 6;
    localparam int unsigned CMD_REMOTE    = 7;
    localparam int unsigned CMD_MEMCLR    = 8;
    localparam int unsigned CMD_CLR_REJ   = 9;
    localparam int unsigned CMD_CLR_ERR   = 10;
    localparam int unsigned ST_RUNNING    = 0;
    localparam int unsigned ST_ENABLED    = 1;
    localparam int unsigned ST_ERROR      = 2;
    localparam int unsigned ST_REJECT     = 3;
    localparam int unsigned ST_TUNE_BLK   = 4;

    // ------------------------------------------------------------
    // codes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RUN_KEY_CODE    = 8'h32;
    localparam logic [15:0] ERR_INSTR_CODE  = 16'h000A;
    localparam logic [15:0] SPEED_INIT      = 16'h00C0;
    localparam logic        FRAME_INIT      = 1'h1;
    localparam logic [1:0]  PARITY_INIT     = 2'h2;
    localparam logic [15:0] CHECK_INIT      = 16'h270F;
    localparam logic [15:0] CHECK_OFF       = 16'h270F;
    localparam int unsigned START_TERM      = 0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] check_interval;
        logic [1:0]  parity;
        logic        frame;
        logic [15:0] link_speed;
    } sqc_comm_type;

    localparam sqc_comm_type COMM_INIT = '{CHECK_INIT, PARITY_INIT, FRAME_INIT, SPEED_INIT};

    typedef struct packed {
        logic [31:0] step;
        logic [15:0] code;
        logic        flag;
    } sqc_err_type;

    typedef enum logic [1:0] {
        SQC_STOP = 2'b01,
        SQC_RUN  = 2'b10
    } sqc_state_type;

endpackage : sqc_pkg

/* verif/sqc_engine_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// engine: scan boundary every 8 cycles, fixed image while running
// ------------------------------------------------------------
module sqc_engine_model (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         run,
    output logic              scan_end,
    output logic      [15:0]  y_image
);
    logic [2:0] cnt;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cnt <= 3'h0;
        else
            cnt <= cnt + 3'h1;
    end
    assign scan_end = (cnt == 3'h7);
    // image is meaningless while stopped, so it toggles
    assign y_image  = run ? 16'hA5A5 : {16{cnt[0]}};
endmodule : sqc_engine_model

/* verif/sqc_run_ctrl_tb.sv */
`timescale 1ns/1ps

module sqc_run_ctrl_tb;
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, clr, fault;
    logic        eng_run, dstart, tune_ok, chk_en, scan;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, fstep, rdata;
    logic [11:0] term, prog;
    logic [15:0] outp, yimg;
    sqc_pkg::sqc_comm_type comm;
    int          mismatches, checks_done;

    always #20 clk = ~clk;

    sqc_engine_model u_eng (.clk(clk), .reset_n(reset_n), .run(eng_run), .scan_end(scan), .y_image(yimg));

    sqc_run_ctrl #(.HOLD_CYC(20)) u_dut (
        .CLK(clk), .RESET_N(reset_n), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TERM_IN(term), .CLEAR_TERM_IN(clr), .REMOTE_CONTACT_IN(1'b0), .NET_RUN_REQ(1'b0),
        .NET_STOP_REQ(1'b0), .SCAN_END(scan), .INSTR_FAULT(fault), .FAULT_STEP(fstep),
        .Y_IMAGE(yimg), .ENGINE_RUN(eng_run), .OUT_POINTS(outp), .PROG_INPUTS(prog),
        .DRIVE_START(dstart), .TUNE_ALLOWED(tune_ok), .COMM_SETTINGS(comm), .COMM_CHECK_EN(chk_en)
    );

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdata = pslverr ? 32'hFFFFFFFF : prdata;
        psel <= 1'b0; penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            mismatches++;
            end_of_test;
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask : rd

    task automatic wait_run(input logic v);
        int n;
        n = 0;
        while (eng_run !== v && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        if (eng_run !== v)
        begin
            mismatches++;
            end_of_test;
        end
        @(negedge clk);
    endtask : wait_run

    initial
    begin
        clk = 0; reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        term = 0; clr = 0; fault = 0; fstep = 0; mismatches = 0; checks_done = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rd(sqc_pkg::OFS_COMM, 32'h002100C0);
        rd(sqc_pkg::OFS_CHECK, 32'h0000270F);
        chk({31'h0, chk_en}, 32'h0);
        term <= 12'h001;
        repeat (5) @(posedge clk);
        chk({31'h0, dstart}, 32'h1);
        term <= 12'h000;
        wr(sqc_pkg::OFS_FORCE, 32'h1);
        repeat (2) @(posedge clk);
        chk({20'h0, prog}, 32'h1);
        chk({31'h0, dstart}, 32'h0);
        $display("reset values done");
        wr(sqc_pkg::OFS_CTRL, 32'h1);
        wr(sqc_pkg::OFS_ASSIGN, 32'h3201);
        rd(sqc_pkg::OFS_STATUS, 32'h0);
        wr(sqc_pkg::OFS_CMD, 32'h8);
        repeat (4) @(posedge clk);
        rd(sqc_pkg::OFS_STATUS, 32'h12);
        chk({31'h0, tune_ok}, 32'h0);
        wr(sqc_pkg::OFS_SLOT0, 32'hFFFF);
        term <= 12'h002;
        wait_run(1'b1);
        repeat (12) @(posedge clk);
        chk({16'h0, outp}, 32'hA5A5);
        fstep <= 32'h00050003;
        fault <= 1'b1;
        @(posedge clk);
        fault <= 1'b0;
        term <= 12'h000;
        wait_run(1'b0);
        chk({16'h0, outp}, 32'h0);
        rd(sqc_pkg::OFS_SLOT0, 32'hFFFF);
        $display("run stop done");
        rd(sqc_pkg::OFS_ERRCODE, 32'hA);
        rd(sqc_pkg::OFS_ERRSTEP, 32'h00050003);
        rd(8'hFC, 32'hFFFFFFFF);
        wr(sqc_pkg::OFS_COMM, 32'h00100060);
        rd(sqc_pkg::OFS_COMM, 32'h00100060);
        chk({16'h0, comm.link_speed}, 32'h60);
        wr(sqc_pkg::OFS_CMD, 32'h4);
        repeat (2) @(posedge clk);
        rd(sqc_pkg::OFS_COMM, 32'h002100C0);
        wr(sqc_pkg::OFS_CMD, 32'h40);
        apb(1'b0, sqc_pkg::OFS_STATUS, 32'h0);
        chk(rdata & 32'h8, 32'h8);
        $display("error and comm done");
        clr <= 1'b1;
        repeat (30) @(posedge clk);
        clr <= 1'b0;
        repeat (10) @(posedge clk);
        rd(sqc_pkg::OFS_ERRCODE, 32'h0);
        rd(sqc_pkg::OFS_ERRSTEP, 32'h0);
        $display("clear terminal done");
        end_of_test;
    end
endmodule : sqc_run_ctrl_tb
